//--- design/bwc_top.sv
// Purpose: Prefetchable and I/O window registers, header tail and bridge control
// Assumes: APB slave, zero wait states, decode inputs synchronous to I_CLOCK
// Notes:   Decode and error outputs are registered, one cycle after their cause
`timescale 1ns/1ps
module bwc_top #(
  parameter int AW = 8
) (
  input  wire logic          I_CLOCK,
  input  wire logic          I_NRST,
  // APB slave
  input  wire logic          I_PSEL,
  input  wire logic          I_PENABLE,
  input  wire logic          I_PWRITE,
  input  wire logic [AW-1:0] I_PADDR,
  input  wire logic [31:0]   I_PWDATA,
  output logic      [31:0]   O_PRDATA,
  output logic               O_PREADY,
  output logic               O_PSLVERR,
  // Lower I/O window nibbles held in the lower header words
  input  wire logic [3:0]    I_IO_BASE_LO,
  input  wire logic [3:0]    I_IO_LIMIT_LO,
  // Prefetchable memory decode
  input  wire logic          I_MEM_VALID,
  input  wire logic [63:0]   I_MEM_ADDR,
  output logic               O_PF_HIT,
  // I/O decode
  input  wire logic          I_IO_VALID,
  input  wire logic [31:0]   I_IO_ADDR,
  output logic               O_IO_FWD_DOWN,
  output logic               O_IO_FWD_UP,
  // Secondary error events, one-cycle pulses
  input  wire logic          I_SEC_PERR,
  input  wire logic          I_SEC_UNCORR,
  input  wire logic          I_SEC_SERR,
  input  wire logic          I_SEC_SERR_FATAL,
  output logic               O_PERR_DETECT,
  output logic               O_UNCORR_REPORT,
  output logic               O_ERR_FATAL,
  output logic               O_ERR_NONFATAL,
  // Control levels to the rest of the bridge
  output logic [7:0]         O_INT_LINE,
  output logic               O_PERR_EN,
  output logic               O_SERR_EN,
  output logic               O_ISA_EN,
  output logic               O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    bwc_pkg::bwc_apb_st_t    apb_st;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [11:0]             pf_base;
    logic [11:0]             pf_limit;
    logic [31:0]             pf_base_hi;
    logic [31:0]             pf_limit_hi;
    logic [15:0]             io_base_hi;
    logic [15:0]             io_limit_hi;
    logic [7:0]              int_line;
    logic                    perr_en;
    logic                    serr_en;
    logic                    isa_en;
    logic [bwc_pkg::EVT_N-1:0] evt_status;
    logic [bwc_pkg::EVT_N-1:0] evt_mask;
    logic                    pf_hit;
    logic                    io_down;
    logic                    io_up;
    logic                    perr_det;
    logic                    uncorr_rep;
    logic                    err_fatal;
    logic                    err_nonfatal;
  } bwc_state_t;

  bwc_state_t st_reg;
  bwc_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Window compares

  logic [63:0] pf_base_full;
  logic [63:0] pf_limit_full;
  logic [31:0] io_base_full;
  logic [31:0] io_limit_full;
  logic        pf_in;
  logic        io_in;
  logic        isa_alias;

  // Low fill bits make the limit cover its whole granule, so the compare is inclusive
  assign pf_base_full  = {st_reg.pf_base_hi, st_reg.pf_base, bwc_pkg::PF_BASE_FILL};
  assign pf_limit_full = {st_reg.pf_limit_hi, st_reg.pf_limit, bwc_pkg::PF_LIMIT_FILL};
  assign io_base_full  = {st_reg.io_base_hi, I_IO_BASE_LO, bwc_pkg::IO_BASE_FILL};
  assign io_limit_full = {st_reg.io_limit_hi, I_IO_LIMIT_LO, bwc_pkg::IO_LIMIT_FILL};

  bwc_window_cmp #(
    .W (64)
  ) u_pf_cmp (
    .i_addr  (I_MEM_ADDR),
    .i_base  (pf_base_full),
    .i_limit (pf_limit_full),
    .o_hit   (pf_in)
  );

  bwc_window_cmp #(
    .W (32)
  ) u_io_cmp (
    .i_addr  (I_IO_ADDR),
    .i_base  (io_base_full),
    .i_limit (io_limit_full),
    .o_hit   (io_in)
  );

  // First 64KB and not the low 256 bytes of a 1KB block
  assign isa_alias = (I_IO_ADDR[31:16] == bwc_pkg::ISA_HIGH_ZERO) &&
                     (I_IO_ADDR[9:8] != bwc_pkg::ISA_LOW_QUART);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic        setup_cyc;
  logic        access_cyc;
  logic        wr_en;
  logic        rd_done;
  logic        addr_ok;
  logic [7:0]  ofs;
  logic [31:0] rd_word;

  assign setup_cyc  = I_PSEL && !I_PENABLE;
  assign access_cyc = I_PSEL && I_PENABLE;
  assign ofs        = 8'(I_PADDR);
  assign wr_en      = access_cyc && I_PWRITE && addr_ok;
  assign rd_done    = access_cyc && !I_PWRITE;

  // Unmapped offsets answer with an error and drop the write
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (ofs)
      bwc_pkg::OFS_PF_LOW: begin
        rd_word[3:0] = bwc_pkg::PF_ADDR64_CODE;
        rd_word[bwc_pkg::PF_BASE_LSB +: 12] = st_reg.pf_base;
        rd_word[bwc_pkg::PF_LIMIT_CODE_LSB +: 4] = bwc_pkg::PF_ADDR64_CODE;
        rd_word[bwc_pkg::PF_LIMIT_LSB +: 12] = st_reg.pf_limit;
      end
      bwc_pkg::OFS_PF_BASE_HI: begin
        rd_word = st_reg.pf_base_hi;
      end
      bwc_pkg::OFS_PF_LIMIT_HI: begin
        rd_word = st_reg.pf_limit_hi;
      end
      bwc_pkg::OFS_IO_HI: begin
        rd_word = {st_reg.io_limit_hi, st_reg.io_base_hi};
      end
      bwc_pkg::OFS_CAP_PTR: begin
        rd_word[7:0] = bwc_pkg::CAP_PTR_VALUE;
      end
      bwc_pkg::OFS_ROM_BASE: begin
        rd_word = bwc_pkg::ROM_BASE_VALUE;
      end
      bwc_pkg::OFS_INT_CTL: begin
        rd_word[7:0] = st_reg.int_line;
        rd_word[bwc_pkg::INT_PIN_LSB +: 8] = bwc_pkg::INT_PIN_VALUE;
        rd_word[bwc_pkg::BC_PERR_EN_BIT] = st_reg.perr_en;
        rd_word[bwc_pkg::BC_SERR_EN_BIT] = st_reg.serr_en;
        rd_word[bwc_pkg::BC_ISA_EN_BIT] = st_reg.isa_en;
      end
      bwc_pkg::OFS_EVT_STATUS: begin
        rd_word[bwc_pkg::EVT_N-1:0] = st_reg.evt_status;
      end
      bwc_pkg::OFS_EVT_MASK: begin
        rd_word[bwc_pkg::EVT_N-1:0] = st_reg.evt_mask;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [bwc_pkg::EVT_N-1:0] evt_set;
  logic [bwc_pkg::EVT_N-1:0] evt_clr;

  always_comb begin
    st_next = st_reg;

    // Read data is captured in setup so the access phase needs no wait
    case (st_reg.apb_st)
      bwc_pkg::APB_IDLE: begin
        if (setup_cyc) begin
          st_next.apb_st  = bwc_pkg::APB_ACCESS;
          st_next.prdata  = I_PWRITE ? 32'h0000_0000 : rd_word;
          st_next.pslverr = !addr_ok;
        end
      end
      bwc_pkg::APB_ACCESS: begin
        // Back-to-back setup is legal: the idle state sees it in the very next cycle
        if (access_cyc) begin
          st_next.apb_st = bwc_pkg::APB_IDLE;
        end
      end
      default: begin
        st_next.apb_st = bwc_pkg::APB_IDLE;
      end
    endcase

    // Register writes; read-only fields keep their constants
    if (wr_en) begin
      case (ofs)
        bwc_pkg::OFS_PF_LOW: begin
          st_next.pf_base  = I_PWDATA[bwc_pkg::PF_BASE_LSB +: 12];
          st_next.pf_limit = I_PWDATA[bwc_pkg::PF_LIMIT_LSB +: 12];
        end
        bwc_pkg::OFS_PF_BASE_HI: begin
          st_next.pf_base_hi = I_PWDATA;
        end
        bwc_pkg::OFS_PF_LIMIT_HI: begin
          st_next.pf_limit_hi = I_PWDATA;
        end
        bwc_pkg::OFS_IO_HI: begin
          st_next.io_base_hi  = I_PWDATA[15:0];
          st_next.io_limit_hi = I_PWDATA[bwc_pkg::IO_LIMIT_LSB +: 16];
        end
        bwc_pkg::OFS_INT_CTL: begin
          st_next.int_line = I_PWDATA[7:0];
          st_next.perr_en  = I_PWDATA[bwc_pkg::BC_PERR_EN_BIT];
          st_next.serr_en  = I_PWDATA[bwc_pkg::BC_SERR_EN_BIT];
          st_next.isa_en   = I_PWDATA[bwc_pkg::BC_ISA_EN_BIT];
        end
        bwc_pkg::OFS_EVT_MASK: begin
          st_next.evt_mask = I_PWDATA[bwc_pkg::EVT_N-1:0];
        end
        default: begin
          st_next.evt_mask = st_reg.evt_mask;
        end
      endcase
    end

    // Window decode, registered
    // A hit shows one cycle after its address; the caller pairs the two
    st_next.pf_hit  = I_MEM_VALID && pf_in;
    st_next.io_down = I_IO_VALID && io_in && !(st_reg.isa_en && isa_alias);
    st_next.io_up   = I_IO_VALID && io_in && st_reg.isa_en && isa_alias;

    // Secondary error handling
    st_next.perr_det     = I_SEC_PERR && st_reg.perr_en;
    st_next.uncorr_rep   = I_SEC_UNCORR && st_reg.perr_en;
    st_next.err_fatal    = I_SEC_SERR && st_reg.serr_en && I_SEC_SERR_FATAL;
    st_next.err_nonfatal = I_SEC_SERR && st_reg.serr_en && !I_SEC_SERR_FATAL;

    // Sticky events; a set in the clearing cycle survives
    evt_set = '0;
    evt_set[bwc_pkg::EVT_PERR]   = st_next.perr_det;
    evt_set[bwc_pkg::EVT_UNCORR] = st_next.uncorr_rep;
    evt_set[bwc_pkg::EVT_SERR]   = st_next.err_fatal || st_next.err_nonfatal;
    // Clear only the bits that the read returned: an event landing at the
    // setup edge is missing from the read word and must stay pending
    evt_clr = '0;
    if (rd_done && (ofs == bwc_pkg::OFS_EVT_STATUS)) begin
      evt_clr = st_reg.prdata[bwc_pkg::EVT_N-1:0];
    end
    st_next.evt_status = (st_reg.evt_status & ~evt_clr) | evt_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Every field resets to a constant; no next-state value reaches the reset branch
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_reg.apb_st       <= bwc_pkg::APB_IDLE;
      st_reg.prdata       <= 32'h0000_0000;
      st_reg.pslverr      <= 1'b0;
      st_reg.pf_base      <= bwc_pkg::PF_BASE_RST;
      st_reg.pf_limit     <= bwc_pkg::PF_LIMIT_RST;
      st_reg.pf_base_hi   <= bwc_pkg::PF_HI_RST;
      st_reg.pf_limit_hi  <= bwc_pkg::PF_HI_RST;
      st_reg.io_base_hi   <= bwc_pkg::IO_HI_RST;
      st_reg.io_limit_hi  <= bwc_pkg::IO_HI_RST;
      st_reg.int_line     <= bwc_pkg::INT_LINE_RST;
      st_reg.perr_en      <= 1'b0;
      st_reg.serr_en      <= 1'b0;
      // ISA mode off after reset: every in-window I/O address goes downstream
      st_reg.isa_en       <= 1'b0;
      st_reg.evt_status   <= bwc_pkg::EVT_RST;
      st_reg.evt_mask     <= bwc_pkg::EVT_RST;
      st_reg.pf_hit       <= 1'b0;
      st_reg.io_down      <= 1'b0;
      st_reg.io_up        <= 1'b0;
      st_reg.perr_det     <= 1'b0;
      st_reg.uncorr_rep   <= 1'b0;
      st_reg.err_fatal    <= 1'b0;
      st_reg.err_nonfatal <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states: every access phase completes at once
  assign O_PREADY        = 1'b1;
  assign O_PRDATA        = st_reg.prdata;
  // The stored flag alone would leak into idle cycles, so gate it with the access phase
  assign O_PSLVERR       = st_reg.pslverr && access_cyc;
  assign O_PF_HIT        = st_reg.pf_hit;
  assign O_IO_FWD_DOWN   = st_reg.io_down;
  assign O_IO_FWD_UP     = st_reg.io_up;
  assign O_PERR_DETECT   = st_reg.perr_det;
  assign O_UNCORR_REPORT = st_reg.uncorr_rep;
  assign O_ERR_FATAL     = st_reg.err_fatal;
  assign O_ERR_NONFATAL  = st_reg.err_nonfatal;
  assign O_INT_LINE      = st_reg.int_line;
  assign O_PERR_EN       = st_reg.perr_en;
  assign O_SERR_EN       = st_reg.serr_en;
  assign O_ISA_EN        = st_reg.isa_en;
  // Level request: stays high until status reads or a mask write leave no unmasked bit set
  assign O_IRQ           = |(st_reg.evt_status & st_reg.evt_mask);

endmodule // bwc_top

//--- design/bwc_pkg.sv
// Purpose: Shared constants for the bridge window and control register slice
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes:   Offsets 0x24..0x3C hold header words; 0xF0/0xF4 hold event status/mask
package bwc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_PF_LOW      = 8'h24;
  localparam logic [7:0] OFS_PF_BASE_HI  = 8'h28;
  localparam logic [7:0] OFS_PF_LIMIT_HI = 8'h2C;
  localparam logic [7:0] OFS_IO_HI       = 8'h30;
  localparam logic [7:0] OFS_CAP_PTR     = 8'h34;
  localparam logic [7:0] OFS_ROM_BASE    = 8'h38;
  localparam logic [7:0] OFS_INT_CTL     = 8'h3C;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'hF0;
  localparam logic [7:0] OFS_EVT_MASK    = 8'hF4;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout and fixed values
  localparam logic [3:0]  PF_ADDR64_CODE   = 4'h1;
  localparam int          PF_BASE_LSB      = 4;
  localparam int          PF_LIMIT_LSB     = 20;
  localparam int          PF_LIMIT_CODE_LSB = 16;
  localparam int          IO_LIMIT_LSB     = 16;
  localparam logic [7:0]  CAP_PTR_VALUE    = 8'h80;
  localparam logic [31:0] ROM_BASE_VALUE   = 32'h0000_0000;
  localparam logic [7:0]  INT_PIN_VALUE    = 8'h01;
  localparam int          INT_PIN_LSB      = 8;
  localparam int          BC_PERR_EN_BIT   = 16;
  localparam int          BC_SERR_EN_BIT   = 17;
  localparam int          BC_ISA_EN_BIT    = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [11:0] PF_BASE_RST    = 12'h800;
  localparam logic [11:0] PF_LIMIT_RST   = 12'h000;
  localparam logic [31:0] PF_HI_RST      = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RST      = 16'h0000;
  localparam logic [7:0]  INT_LINE_RST   = 8'h00;
  localparam logic [2:0]  EVT_RST        = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Window geometry and ISA alias decode
  localparam int          PF_FILL_BITS   = 20;
  localparam int          IO_FILL_BITS   = 12;
  localparam logic [19:0] PF_LIMIT_FILL  = 20'hFFFFF;
  localparam logic [19:0] PF_BASE_FILL   = 20'h00000;
  localparam logic [11:0] IO_LIMIT_FILL  = 12'hFFF;
  localparam logic [11:0] IO_BASE_FILL   = 12'h000;
  localparam logic [15:0] ISA_HIGH_ZERO  = 16'h0000;
  localparam logic [1:0]  ISA_LOW_QUART  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Event status bits
  localparam int EVT_PERR   = 0;
  localparam int EVT_UNCORR = 1;
  localparam int EVT_SERR   = 2;
  localparam int EVT_N      = 3;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } bwc_apb_st_t;

endpackage

//--- design/bwc_window_cmp.sv
// Purpose: Inclusive base-to-limit window compare
// Assumes: Base and limit already carry their filled low bits
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module bwc_window_cmp #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] i_addr,
  input  wire logic [W-1:0] i_base,
  input  wire logic [W-1:0] i_limit,
  output logic              o_hit
);

  // Base above limit yields no hit, which closes the window
  assign o_hit = (i_addr >= i_base) && (i_addr <= i_limit);

endmodule // bwc_window_cmp

//--- tb/bwc_sva.sv
// Purpose: Temporal checks on the window and control slice
// Assumes: Zero-wait APB, decode and events registered one cycle
// Notes:   Bound to bwc_top; sees its ports only
`timescale 1ns/1ps
module bwc_sva #(
  parameter int AW = 8
) (
  input wire logic          I_CLOCK,
  input wire logic          I_NRST,
  input wire logic          I_PSEL,
  input wire logic          I_PENABLE,
  input wire logic          I_PWRITE,
  input wire logic [AW-1:0] I_PADDR,
  input wire logic [31:0]   I_PWDATA,
  input wire logic [31:0]   O_PRDATA,
  input wire logic          O_PSLVERR,
  input wire logic          I_IO_VALID,
  input wire logic [31:0]   I_IO_ADDR,
  input wire logic          O_IO_FWD_DOWN,
  input wire logic          O_IO_FWD_UP,
  input wire logic          I_SEC_PERR,
  input wire logic          I_SEC_UNCORR,
  input wire logic          I_SEC_SERR,
  input wire logic          I_SEC_SERR_FATAL,
  input wire logic          O_PERR_DETECT,
  input wire logic          O_UNCORR_REPORT,
  input wire logic          O_ERR_FATAL,
  input wire logic          O_ERR_NONFATAL,
  input wire logic [7:0]    O_INT_LINE,
  input wire logic          O_PERR_EN,
  input wire logic          O_SERR_EN,
  input wire logic          O_ISA_EN
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  logic isa_alias;
  // Alias decode kept here so the up and down checks share one view
  assign isa_alias = I_IO_VALID && O_ISA_EN && I_IO_ADDR[31:16] == 16'h0000 && I_IO_ADDR[9:8] != 2'h0;
  sequence rd_acc(a);
    I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR[7:0] == a;
  endsequence
  sequence wr_acc(a);
    I_PSEL && I_PENABLE && I_PWRITE && I_PADDR[7:0] == a;
  endsequence
  pf_code_a: assert property (rd_acc(8'h24) |-> O_PRDATA[3:0] == 4'h1 && O_PRDATA[19:16] == 4'h1)
    else $error("addressing code wrong");
  cap_ptr_a: assert property (rd_acc(8'h34) |-> O_PRDATA == 32'h0000_0080)
    else $error("capability pointer wrong");
  rom_zero_a: assert property (rd_acc(8'h38) |-> O_PRDATA == 32'h0000_0000)
    else $error("option rom word not zero");
  int_pin_a: assert property (rd_acc(8'h3C) |-> O_PRDATA[15:8] == 8'h01 && O_PRDATA[7:0] == O_INT_LINE)
    else $error("interrupt pin byte wrong");
  ctl_write_a: assert property (wr_acc(8'h3C) |=> O_INT_LINE == $past(I_PWDATA[7:0])
    && {O_ISA_EN, O_SERR_EN, O_PERR_EN} == $past(I_PWDATA[18:16])) else $error("control write lost");
  perr_gate_a: assert property (O_PERR_DETECT == ($past(I_SEC_PERR) && $past(O_PERR_EN)))
    else $error("parity detect gating wrong");
  uncorr_gate_a: assert property (I_SEC_UNCORR ##1 O_UNCORR_REPORT |-> $past(O_PERR_EN))
    else $error("uncorrectable report while disabled");
  fatal_fwd_a: assert property (I_SEC_SERR && I_SEC_SERR_FATAL && O_SERR_EN |=> O_ERR_FATAL)
    else $error("fatal not forwarded");
  nonfatal_fwd_a: assert property (O_ERR_NONFATAL |-> $past(I_SEC_SERR) && !$past(I_SEC_SERR_FATAL))
    else $error("nonfatal without cause");
  serr_off_a: assert property (!O_SERR_EN |=> !O_ERR_FATAL && !O_ERR_NONFATAL)
    else $error("forwarding while disabled");
  io_up_a: assert property (O_IO_FWD_UP |-> $past(isa_alias) && !O_IO_FWD_DOWN)
    else $error("upstream forward without alias");
  io_down_a: assert property (O_IO_FWD_DOWN |-> !$past(isa_alias))
    else $error("alias forwarded downstream");
  slverr_phase_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("error outside access");
endmodule // bwc_sva
bind bwc_top bwc_sva #(.AW(AW)) bwc_sva_inst (.*);

//--- tb/bwc_apb_master.sv
// Purpose: Upstream requester issuing APB configuration transfers
// Assumes: One request per i_go pulse, taken only while idle
// Notes:   Released address and data are inverted, never left stale
`timescale 1ns/1ps
module bwc_apb_master (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_go,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr,
  output logic             o_psel    = 1'b0,
  output logic             o_penable = 1'b0,
  output logic             o_pwrite  = 1'b0,
  output logic [7:0]       o_paddr   = 8'h00,
  output logic [31:0]      o_pwdata  = 32'h0000_0000,
  output logic             o_done    = 1'b0,
  output logic [31:0]      o_rdata   = 32'h0000_0000,
  output logic             o_err     = 1'b0
);
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_psel && i_go) begin
        o_psel <= 1'b1;
        o_pwrite <= i_wr;
        o_paddr <= i_addr;
        o_pwdata <= i_wdata;
      end else if (o_psel && !o_penable) begin
        o_penable <= 1'b1;
      end else if (o_penable && i_pready) begin
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~o_paddr;
        o_pwdata <= ~o_pwdata;
        o_rdata <= i_prdata;
        o_err <= i_pslverr;
        o_done <= 1'b1;
      end
    end
  end
endmodule // bwc_apb_master

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the window and control slice
// Assumes: Shadow copies of written words predict every read
// Notes:   Random values from a fixed xorshift seed
`timescale 1ns/1ps
module tb_top;
  logic        I_CLOCK = 1'b0, I_NRST = 1'b0, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
  logic [7:0]  I_PADDR, O_INT_LINE, ad = 8'h00;
  logic [31:0] I_PWDATA, O_PRDATA, rdata, wd = 32'h0000_0000, t, u, ilo, ihi, im[5];
  logic [3:0]  I_IO_BASE_LO = 4'h0, I_IO_LIMIT_LO = 4'h0, evs[4] = '{4'h4, 4'h8, 4'h3, 4'h2};
  logic        I_MEM_VALID = 1'b0, I_IO_VALID = 1'b0, O_PF_HIT, O_IO_FWD_DOWN, O_IO_FWD_UP;
  logic [63:0] I_MEM_ADDR = 64'h0, plo, phi, pm[5];
  logic [31:0] I_IO_ADDR = 32'h0, sh24, sh28, sh2c, sh30, sh3c, seed = 32'h0001_1571;
  logic        I_SEC_PERR = 1'b0, I_SEC_UNCORR = 1'b0, I_SEC_SERR = 1'b0, I_SEC_SERR_FATAL = 1'b0;
  logic        O_PERR_DETECT, O_UNCORR_REPORT, O_ERR_FATAL, O_ERR_NONFATAL, O_PERR_EN, O_SERR_EN;
  logic        O_ISA_EN, O_IRQ, go = 1'b0, wr = 1'b0, done, err;
  logic [2:0]  st, sh_mask;
  logic [7:0]  offs[9] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'hF4, 8'hF0};
  logic [7:0]  bad[3] = '{8'h40, 8'h26, 8'hF8};
  int          n_fail = 0, n_compared = 0, j, k;
  always #12.5 I_CLOCK = ~I_CLOCK;
  bwc_top bwc_top_inst (.*);
  bwc_apb_master bwc_apb_master_inst (.i_clk(I_CLOCK), .i_nrst(I_NRST), .i_go(go), .i_wr(wr),
    .i_addr(ad), .i_wdata(wd), .i_pready(O_PREADY), .i_prdata(O_PRDATA), .i_pslverr(O_PSLVERR),
    .o_psel(I_PSEL), .o_penable(I_PENABLE), .o_pwrite(I_PWRITE), .o_paddr(I_PADDR),
    .o_pwdata(I_PWDATA), .o_done(done), .o_rdata(rdata), .o_err(err));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h24: return (sh24 & 32'hFFF0_FFF0) | 32'h0001_0001;
      8'h28: return sh28;
      8'h2C: return sh2c;
      8'h30: return sh30;
      8'h34: return 32'h0000_0080;
      8'h3C: return {13'h0000, sh3c[18:16], 8'h01, sh3c[7:0]};
      8'hF4: return {29'h0, sh_mask};
      8'hF0: return {29'h0, st};
      default: return 32'h0000_0000;
    endcase
  endfunction
  function automatic logic pf_in(input logic [63:0] m);
    return m >= {sh28, sh24[15:4], 20'h00000} && m <= {sh2c, sh24[31:20], 20'hFFFFF};
  endfunction
  function automatic logic [1:0] io_exp(input logic [31:0] i);
    logic w;
    logic s;
    w = i >= {sh30[15:0], I_IO_BASE_LO, 12'h000} && i <= {sh30[31:16], I_IO_LIMIT_LO, 12'hFFF};
    s = sh3c[18] && i[31:16] == 16'h0000 && i[9:8] != 2'h0;
    return {w && !s, w && s};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Counts: compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic shadow_rst();
    sh24 = 32'h0000_8000;
    {sh28, sh2c, sh30, sh3c} = {4{32'h0000_0000}};
    {st, sh_mask} = 6'h00;
  endtask
  // Waits on the requester's done flag; a stuck bus ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLOCK);
    {go, wr, ad, wd} <= {1'b1, w, a, d};
    @(posedge I_CLOCK);
    go <= 1'b0;
    for (k = 0; k < 20; k++) begin
      @(posedge I_CLOCK);
      if (done === 1'b1) break;
    end
    if (k == 20) begin
      chk({31'h0, done}, 32'h1);
      final_report();
    end
    if (w) begin
      case (a)
        8'h24: sh24 = d;
        8'h28: sh28 = d;
        8'h2C: sh2c = d;
        8'h30: sh30 = d;
        8'h3C: sh3c = d;
        8'hF4: sh_mask = d[2:0];
        default: ;
      endcase
    end else if (a == 8'hF0) st = 3'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] e;
    e = exp_rd(a);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask
  task automatic probe(input logic [63:0] m, input logic [31:0] i);
    @(posedge I_CLOCK);
    {I_MEM_VALID, I_MEM_ADDR, I_IO_VALID, I_IO_ADDR} <= {1'b1, m, 1'b1, i};
    @(posedge I_CLOCK);
    {I_MEM_VALID, I_MEM_ADDR, I_IO_VALID, I_IO_ADDR} <= {1'b0, ~m, 1'b0, ~i};
    @(posedge I_CLOCK);
    chk({29'h0, O_PF_HIT, O_IO_FWD_DOWN, O_IO_FWD_UP}, {29'h0, pf_in(m), io_exp(i)});
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge I_CLOCK);
    {I_SEC_PERR, I_SEC_UNCORR, I_SEC_SERR, I_SEC_SERR_FATAL} <= v;
    @(posedge I_CLOCK);
    {I_SEC_PERR, I_SEC_UNCORR, I_SEC_SERR, I_SEC_SERR_FATAL} <= 4'h0;
    @(posedge I_CLOCK);
    st = st | {v[1] & sh3c[17], v[2] & sh3c[16], v[3] & sh3c[16]};
    chk({27'h0, O_PERR_DETECT, O_UNCORR_REPORT, O_ERR_FATAL, O_ERR_NONFATAL, O_IRQ},
        {27'h0, v[3] & sh3c[16], v[2] & sh3c[16], v[1] & v[0] & sh3c[17], v[1] & ~v[0] & sh3c[17],
         |(st & sh_mask)});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    shadow_rst();
    repeat (6) @(posedge I_CLOCK);
    I_NRST <= 1'b1;
    foreach (offs[j]) rd_chk(offs[j]);
    probe(64'h0000_0000_8000_0000, 32'h0000_0000);
    $display("Test reset values done");
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24);
    for (j = 0; j < 20; j++) begin
      t = rnd();
      apb(1'b1, offs[t[2:0]], rnd());
      rd_chk(offs[t[2:0]]);
    end
    foreach (bad[j]) begin
      apb(1'b1, bad[j], 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, bad[j], 32'h0000_0000);
      chk({31'h0, err}, 32'h1);
      chk(rdata, 32'h0000_0000);
    end
    $display("Test register access done");
    for (j = 0; j < 4; j++) begin
      t = rnd();
      u = rnd();
      {I_IO_BASE_LO, I_IO_LIMIT_LO} <= {1'b0, t[2:0], 1'b1, t[5:3]};
      apb(1'b1, 8'h30, j[1] ? {u[15:0], u[15:0]} : 32'h0000_0000);
      apb(1'b1, 8'h3C, {13'h0000, j[0], 10'h000, u[7:0]});
      apb(1'b1, 8'h24, {1'b1, t[22:12], 4'h0, 1'b0, t[18:8], 4'h0});
      apb(1'b1, 8'h28, u);
      apb(1'b1, 8'h2C, u + {31'h0, j[0]});
      plo = {sh28, sh24[15:4], 20'h00000};
      phi = {sh2c, sh24[31:20], 20'hFFFFF};
      ilo = {sh30[15:0], I_IO_BASE_LO, 12'h000};
      ihi = {sh30[31:16], I_IO_LIMIT_LO, 12'hFFF};
      pm = '{plo, plo - 64'h1, phi, phi + 64'h1, plo + {40'h0, t[23:0]}};
      im = '{ilo, ilo - 32'h1, ihi, ihi + 32'h1, ilo + {20'h0, u[11:0]}};
      foreach (pm[k]) probe(pm[k], im[k]);
    end
    $display("Test window decode done");
    for (j = 0; j < 2; j++) begin
      apb(1'b1, 8'hF4, 32'h0000_0005);
      apb(1'b1, 8'h3C, {14'h0000, j[0], j[0], 16'h0000});
      foreach (evs[k]) ev(evs[k]);
      rd_chk(8'hF0);
      rd_chk(8'hF0);
      chk({31'h0, O_IRQ}, 32'h0);
    end
    $display("Test error events done");
    I_NRST <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    I_NRST <= 1'b1;
    shadow_rst();
    foreach (offs[j]) rd_chk(offs[j]);
    $display("Test second reset done");
    final_report();
  end
endmodule // tb_top
